/* File: core/interrupt_log_buffer_writer.sv */
`default_nettype none
// Overview of operation
// - Log is 64 words at 0x0180..0x01BF.
// - Two words written per enabled record.
// - Pointer wraps to 0x0180 after 32nd record.
// - Pointer visible in bits 8:0 at 0x000A.
// - Id word even address, address word odd.
// - Id word mirrors source pending layout.
// - Hardware and controller ids use their layouts.
// - Monitor and terminal ids use their layouts.
// - Id word may hold several set bits.
// - Hardware records write address word zero.
// - Controller address word is block address.
// - Simple monitor uses command buffer address.
// - Packet monitor uses data buffer address.
// - Terminal uses descriptor table address.
// - One merged record per source per message.
// - Separate record for each source involved.
// - Output-enabled events ORed into one pulse.
// - Master and soft reset set pointer 0x0180.
// - Only enabled event bits are logged.
// - Count in 15:9 saturates, clears on read.
// - Pointer bits 8:6 read 110, always even.
// - Register reads 0x0180 after master reset.
module interrupt_log_buffer_writer
  import log_writer_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Interrupt events
  input wire logic [NSRC-1:0] ev_valid,
  input wire logic [NSRC-1:0][15:0] ev_bits,
  input wire logic [15:0] bc_block_addr,
  input wire logic [15:0] mt_cmd_addr,
  input wire logic [15:0] mt_pkt_addr,
  input wire logic [15:0] rt1_desc_addr,
  input wire logic [15:0] rt2_desc_addr,
  // Log RAM write port
  output logic ram_we,
  output logic [15:0] ram_addr,
  output logic [15:0] ram_wdata,
  // Host interrupt
  output logic host_irq,
  // Mode
  output logic packet_monitor_mode,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    wr_state_t st;
    logic [2:0] cur;
    logic [15:0] wr_aw;
    logic [IDX_W-1:0] rec;
    logic [CNT_W-1:0] cnt;
    logic [NSRC-1:0] busy;
    logic [NSRC-1:0][15:0] id_w;
    logic [NSRC-1:0][15:0] addr_w;
    logic [NSRC-1:0][15:0] en;
    logic [NSRC-1:0][15:0] oe;
    logic pkt_mon;
    logic irq;
    logic ram_we;
    logic [15:0] ram_addr;
    logic [15:0] ram_wdata;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t c;
  state_t n;
  logic [NSRC-1:0][15:0] src_aw;
  logic [15:0] ptr_word;
  logic [7:0] rd_idx;
  logic [7:0] wr_idx;

  // Address word per source
  always_comb begin
    src_aw[SRC_HW] = HW_ADDR_WORD;
    src_aw[SRC_BC] = bc_block_addr;
    src_aw[SRC_MT] = c.pkt_mon ? mt_pkt_addr : mt_cmd_addr;
    src_aw[SRC_RT1] = rt1_desc_addr;
    src_aw[SRC_RT2] = rt2_desc_addr;
  end

  assign ptr_word = {c.cnt, PTR_TAG, c.rec, 1'b0};
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];
  assign wr_idx = c.awaddr[ADDR_W-1:2];

  always_comb begin
    logic [15:0] masked;
    logic irq_any;
    logic rd_clear;
    logic soft_rst;
    logic [15:0] wv;
    masked = '0;
    irq_any = 1'b0;
    rd_clear = 1'b0;
    soft_rst = 1'b0;
    wv = '0;
    n = c;
    n.ram_we = 1'b0;

    // Read channel
    if (c.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !c.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = '0;
      if (rd_idx == REG_PTR) begin
        n.rdata[15:0] = ptr_word;
        rd_clear = 1'b1;
      end else if (rd_idx >= REG_EN_BASE && rd_idx < REG_EN_BASE + 8'(NSRC)) begin
        n.rdata[15:0] = c.en[3'(rd_idx - REG_EN_BASE)];
      end else if (rd_idx >= REG_OE_BASE && rd_idx < REG_OE_BASE + 8'(NSRC)) begin
        n.rdata[15:0] = c.oe[3'(rd_idx - REG_OE_BASE)];
      end else if (rd_idx == REG_CTRL) begin
        n.rdata[CTRL_PKT_MON] = c.pkt_mon;
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end

    // Write channel: address and data taken in either order
    if (c.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s_axi_awvalid && !c.aw_have) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !c.w_have) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (c.aw_have && c.w_have && !c.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      if (wr_idx >= REG_EN_BASE && wr_idx < REG_EN_BASE + 8'(NSRC)) begin
        wv = c.en[3'(wr_idx - REG_EN_BASE)];
        if (c.wstrb[0]) wv[7:0] = c.wdata[7:0];
        if (c.wstrb[1]) wv[15:8] = c.wdata[15:8];
        n.en[3'(wr_idx - REG_EN_BASE)] = wv;
      end else if (wr_idx >= REG_OE_BASE && wr_idx < REG_OE_BASE + 8'(NSRC)) begin
        wv = c.oe[3'(wr_idx - REG_OE_BASE)];
        if (c.wstrb[0]) wv[7:0] = c.wdata[7:0];
        if (c.wstrb[1]) wv[15:8] = c.wdata[15:8];
        n.oe[3'(wr_idx - REG_OE_BASE)] = wv;
      end else if (wr_idx == REG_CTRL) begin
        if (c.wstrb[0]) begin
          n.pkt_mon = c.wdata[CTRL_PKT_MON];
          soft_rst = c.wdata[CTRL_SOFT_RST];
        end
      end else if (wr_idx != REG_PTR) begin
        n.bresp = RESP_SLVERR;
      end else begin
        n.bresp = RESP_SLVERR;
      end
    end

    // Record writer
    case (c.st)
      ST_IDLE: begin
        for (int i = NSRC - 1; i >= 0; i--) begin
          if (c.busy[i]) begin
            n.cur = 3'(i);
          end
        end
        if (|c.busy) begin
          n.st = ST_ID;
          n.ram_we = 1'b1;
          n.ram_addr = LOG_BASE | {10'h000, c.rec, 1'b0};
          n.ram_wdata = c.id_w[n.cur];
          n.wr_aw = c.addr_w[n.cur];
          n.busy[n.cur] = 1'b0;
        end
      end
      ST_ID: begin
        n.st = ST_ADDR;
        n.ram_we = 1'b1;
        n.ram_addr = c.ram_addr | 16'h0001;
        n.ram_wdata = c.wr_aw;
      end
      ST_ADDR: begin
        n.st = ST_IDLE;
        n.rec = c.rec + 5'h01;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Count: cleared by read, a record in the same cycle still counts
    if (rd_clear) begin
      n.cnt = '0;
    end
    if (c.st == ST_ADDR && n.cnt != CNT_MAX) begin
      n.cnt = n.cnt + 7'h01;
    end

    // Event capture; a new event wins over the slot being emptied
    for (int i = 0; i < NSRC; i++) begin
      masked = ev_bits[i] & c.en[i];
      if (ev_valid[i] && |masked) begin
        if (n.busy[i]) begin
          n.id_w[i] = n.id_w[i] | masked;
        end else begin
          n.id_w[i] = masked;
        end
        n.addr_w[i] = src_aw[i];
        n.busy[i] = 1'b1;
        irq_any = irq_any | (|(masked & c.oe[i]));
      end
    end
    n.irq = irq_any;

    if (soft_rst) begin
      n.rec = '0;
      n.cnt = '0;
      n.st = ST_IDLE;
      n.ram_we = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c <= '0;
      c.st <= ST_IDLE;
    end else begin
      c <= n;
    end
  end

  assign ram_we = c.ram_we;
  assign ram_addr = c.ram_addr;
  assign ram_wdata = c.ram_wdata;
  assign host_irq = c.irq;
  assign packet_monitor_mode = c.pkt_mon;
  assign s_axi_awready = !c.aw_have;
  assign s_axi_wready = !c.w_have;
  assign s_axi_bvalid = c.bvalid;
  assign s_axi_bresp = c.bresp;
  assign s_axi_arready = !c.rvalid;
  assign s_axi_rvalid = c.rvalid;
  assign s_axi_rdata = c.rdata;
  assign s_axi_rresp = c.rresp;

endmodule // interrupt_log_buffer_writer
`default_nettype wire

/* File: core/log_writer_pkg.sv */
`default_nettype none
package log_writer_pkg;
  // Event sources, fixed priority: lowest index is written first
  localparam int NSRC = 5;
  localparam int SRC_HW = 0;
  localparam int SRC_BC = 1;
  localparam int SRC_MT = 2;
  localparam int SRC_RT1 = 3;
  localparam int SRC_RT2 = 4;

  // Log region in RAM
  localparam logic [15:0] LOG_BASE = 16'h0180;
  localparam logic [15:0] LOG_LAST = 16'h01bf;
  localparam logic [15:0] HW_ADDR_WORD = 16'h0000;
  localparam int IDX_W = 5;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h7f;
  localparam logic [2:0] PTR_TAG = 3'h6;

  // Register indices; byte address is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] REG_PTR = 8'h0a;
  localparam logic [7:0] REG_EN_BASE = 8'h10;
  localparam logic [7:0] REG_OE_BASE = 8'h18;
  localparam logic [7:0] REG_CTRL = 8'h20;
  localparam int CTRL_PKT_MON = 0;
  localparam int CTRL_SOFT_RST = 1;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ID = 3'h2,
    ST_ADDR = 3'h4
  } wr_state_t;
endpackage
`default_nettype wire

/* File: tb/host_log_ram.sv */
`default_nettype none
module host_log_ram (
  // Log write port
  input wire logic aclk,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  // Host view of the first log word
  output logic [15:0] word0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [64];
  always @(posedge aclk) if (ram_we) mem[ram_addr[5:0]] <= ram_wdata;
  assign word0 = mem[0];
endmodule // host_log_ram
`default_nettype wire

/* File: tb/interrupt_log_buffer_writer_props.sv */
`default_nettype none
module ilbw_props
  import log_writer_pkg::*;
(
  // Clock, events, log port
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NSRC-1:0] ev_valid,
  input wire logic ram_we,
  input wire logic [15:0] ram_addr,
  input wire logic host_irq,
  // Register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  logic [15:0] nxt_r;
  logic seen_r;
  wire aw_ok = s_axi_awvalid && s_axi_awready;
  wire ar_ok = s_axi_arvalid && s_axi_arready;
  // Expected start of next record; unknown after a control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nxt_r <= LOG_BASE;
      seen_r <= 1'b1;
    end else if (aw_ok && s_axi_awaddr == {REG_CTRL, 2'b00}) begin
      seen_r <= 1'b0;
    end else if (ram_we && ram_addr[0]) begin
      nxt_r <= (ram_addr == LOG_LAST) ? LOG_BASE : ram_addr + 16'h1;
      seen_r <= 1'b1;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  log_range_a: assert property (ram_we |-> ram_addr >= LOG_BASE && ram_addr <= LOG_LAST)
    else $error("write outside log");
  word_pair_a: assert property (ram_we && !ram_addr[0] |=> ram_we && ram_addr == $past(ram_addr) + 16'h1)
    else $error("record words split");
  rec_gap_a: assert property (ram_we && ram_addr[0] |=> !ram_we)
    else $error("third word written");
  rec_order_a: assert property (ram_we && !ram_addr[0] && seen_r |-> ram_addr == nxt_r)
    else $error("record address wrong");
  irq_cause_a: assert property (host_irq |-> $past(ev_valid) != '0)
    else $error("irq without event");
  ptr_fmt_a: assert property (ar_ok && s_axi_araddr == {REG_PTR, 2'b00} |=> s_axi_rvalid
    && s_axi_rdata[8:6] == PTR_TAG && !s_axi_rdata[0] && s_axi_rdata[31:16] == 16'h0) else $error("pointer format");
  ptr_ro_a: assert property (aw_ok && s_axi_awaddr == {REG_PTR, 2'b00} |-> ##[1:3] s_axi_bvalid
    && s_axi_bresp == RESP_SLVERR) else $error("pointer written");
  bad_addr_a: assert property (ar_ok && s_axi_araddr == 10'h3fc |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read okay");
endmodule // ilbw_props
bind interrupt_log_buffer_writer ilbw_props props (.*);
`default_nettype wire

/* File: tb/test_interrupt_log_buffer_writer.sv */
`default_nettype none
module test_interrupt_log_buffer_writer;
  timeunit 1ns;
  timeprecision 100ps;
  import log_writer_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, ram_we, host_irq, packet_monitor_mode;
  logic [NSRC-1:0] ev_valid = '0;
  logic [NSRC-1:0][15:0] ev_bits = '0;
  logic [15:0] bc_block_addr = '0, mt_cmd_addr = '0, mt_pkt_addr = '0, rt1_desc_addr = '0, rt2_desc_addr = '0;
  logic [15:0] ram_addr, ram_wdata, word0, e0, en [5], oe [5];
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] rq [$];
  logic [33:0] aq [$];
  int bad_count = 0, compares = 0, rec = 0, cnt = 0, pm = 0;
  interrupt_log_buffer_writer uut (.*);
  host_log_ram partner (.*);
  always #12.5 aclk = ~aclk;

  task automatic complete_run;
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_ram(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected ram_word exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_ax(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected axi_resp exp %h got %h", e, g);
    end
  endtask
  task automatic cmp_pin(input string nm, input logic g, input logic e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic hang(input int i);
    if (i >= 20) begin
      bad_count++;
      complete_run();
    end
  endtask
  // Results checked in arrival order
  always @(posedge aclk) begin
    if (ram_we) cmp_ram({ram_addr, ram_wdata}, rq.size() ? rq.pop_front() : 'x);
    if (s_axi_bvalid && s_axi_bready) cmp_ax({s_axi_bresp, 32'h0}, aq.size() ? aq.pop_front() : 'x);
    if (s_axi_rvalid && s_axi_rready) cmp_ax({s_axi_rresp, s_axi_rdata}, aq.size() ? aq.pop_front() : 'x);
  end
  task automatic put(input logic [15:0] id, input logic [15:0] aw);
    rq.push_back({LOG_BASE + 16'(2 * rec), id});
    rq.push_back({LOG_BASE + 16'(2 * rec + 1), aw});
    if (rec == 0) e0 = id;
    rec = (rec + 1) % 32;
    cnt = cnt < 127 ? cnt + 1 : 127;
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] r);
    int i = 0;
    aq.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      i++;
    end while (!s_axi_bvalid && i < 20);
    s_axi_bready <= 1'b0;
    hang(i);
  endtask
  task automatic rd(input logic [9:0] a, input logic [33:0] e);
    int i = 0;
    aq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      i++;
    end while (!s_axi_rvalid && i < 20);
    s_axi_rready <= 1'b0;
    hang(i);
  endtask
  task automatic rdp;
    rd({REG_PTR, 2'b00}, {RESP_OKAY, 16'h0, 7'(cnt), PTR_TAG, 5'(rec), 1'b0});
    cnt = 0;
  endtask
  task automatic ev(input logic [4:0] m, input logic [15:0] bm = 16'hffff);
    logic [15:0] a [6];
    logic [15:0] b;
    logic x;
    int i;
    x = 1'b0;
    @(posedge aclk);
    for (i = 0; i < 6; i++) a[i] = 16'($urandom);
    for (i = 0; i < 5; i++) begin
      b = 16'($urandom) & bm;
      ev_bits[i] <= b;
      if (m[i] && (b & en[i] & oe[i]) != 0) x = 1'b1;
      if (m[i] && (b & en[i]) != 0) put(b & en[i], i == 0 ? HW_ADDR_WORD : (i == 2 && pm != 0) ? a[5] : a[i]);
    end
    bc_block_addr <= a[1];
    mt_cmd_addr <= a[2];
    rt1_desc_addr <= a[3];
    rt2_desc_addr <= a[4];
    mt_pkt_addr <= a[5];
    ev_valid <= m;
    @(posedge aclk);
    ev_valid <= '0;
    @(posedge aclk);
    cmp_pin("host_irq", host_irq, x);
    for (i = 0; i < 20 && rq.size() > 0; i++) @(posedge aclk);
    hang(i);
  endtask

  initial begin
    void'($urandom(42910));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdp();
    for (int i = 0; i < 5; i++) begin
      en[i] = 16'($urandom) | 16'h1;
      wr({8'(REG_EN_BASE + i), 2'b00}, {16'h0, en[i]}, RESP_OKAY);
      oe[i] = 16'($urandom);
      wr({8'(REG_OE_BASE + i), 2'b00}, {16'h0, oe[i]}, RESP_OKAY);
    end
    ev(5'h1f);
    en[4] = 16'h1;
    wr({8'(REG_EN_BASE + 4), 2'b00}, 32'h1, RESP_OKAY);
    ev(5'h10, 16'hfffe);
    repeat (40) ev(5'($urandom));
    rdp();
    rdp();
    wr({REG_PTR, 2'b00}, 32'h0, RESP_SLVERR);
    rd(10'h3fc, {RESP_SLVERR, 32'h0});
    wr({REG_CTRL, 2'b00}, 32'h1, RESP_OKAY);
    pm = 1;
    cmp_pin("packet_monitor_mode", packet_monitor_mode, 1'b1);
    ev(5'h04);
    wr({REG_CTRL, 2'b00}, 32'h2, RESP_OKAY);
    {pm, rec, cnt} = '0;
    cmp_pin("packet_monitor_mode", packet_monitor_mode, 1'b0);
    rdp();
    ev(5'h1f);
    cmp_ram({LOG_BASE, word0}, {LOG_BASE, e0});
    complete_run();
  end
endmodule // test_interrupt_log_buffer_writer
`default_nettype wire
